// ### src/hnr_async_engine.sv
// Async-list descriptor engine: NAK retry, completion bitmap, interrupt flags
// ----------------------------------------------------------------
// Notes on behaviour
// R1: Reload zero: NAK countdown ignored, NAK-ed IN token reissued without limit.
// R2: Reload and countdown 1111b: count NAKs, interrupt when countdown reaches zero.
// R3: Reload and countdown 0000b, error count 10b: no NAK interrupt, retry until answered.
// R4: Async-list events set the async_list_irq bit at offset 310h.
// R5: Reading the completion bitmap clears exactly the bits it returned.
// R6: Bits set during or after a bitmap read survive; interrupt stays asserted.
// R7: On completion the descriptor's valid bit is updated in the store.
// R8: A start-of-frame interrupt is offered for polling the completion bits.
// ----------------------------------------------------------------
`timescale 1ns/1ps
module hnr_async_engine #(
	parameter int FRAME_CYCLES = hnr_pkg::FRAME_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic tok_valid,
	output logic [hnr_pkg::IDX_W-1:0] tok_index,
	input wire logic resp_valid,
	input wire logic [1:0] resp_code,
	output logic irq
);
	localparam int FW = $clog2(FRAME_CYCLES + 1);
	localparam logic [FW-1:0] FRAME_LAST = FW'(FRAME_CYCLES - 1);
	localparam int ND = hnr_pkg::NUM_DESC;

	typedef struct packed {
		hnr_pkg::hnr_state_t state;
		logic [hnr_pkg::IDX_W-1:0] ptr;
		logic [hnr_pkg::DESC_W-1:0] desc;
		logic [ND-1:0] done_map;
		logic async_flag;
		logic sof_flag;
		logic [31:0] enable;
		logic [FW-1:0] frame_cnt;
		logic [31:0] rdata;
		logic desc_rd;
		logic irq;
	} hnr_eng_state_t;

	hnr_eng_state_t st_reg;
	hnr_eng_state_t st_next;

	logic [hnr_pkg::DESC_W-1:0] eng_rd_data;
	logic [hnr_pkg::DESC_W-1:0] sw_rd_data;
	logic mem_wr_en;
	logic [hnr_pkg::IDX_W-1:0] mem_wr_addr;
	logic [hnr_pkg::DESC_W-1:0] mem_wr_data;
	logic desc_hit;
	logic [hnr_pkg::IDX_W-1:0] desc_idx;

	assign desc_hit = (reg_addr & hnr_pkg::OFS_DESC_MASK) == hnr_pkg::OFS_DESC_BASE;
	assign desc_idx = reg_addr[hnr_pkg::DESC_IDX_LSB +: hnr_pkg::IDX_W];

	// ----------------------------------------------------------------
	// Descriptor store
	// ----------------------------------------------------------------
	hnr_desc_mem u_mem (
		.ref_clk(ref_clk),
		.rst(rst),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_data(mem_wr_data),
		.rd_a_addr(st_reg.ptr),
		.rd_a_data(eng_rd_data),
		.rd_b_addr(desc_idx),
		.rd_b_data(sw_rd_data)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic [3:0] reload;
	logic [3:0] nak_countdown;
	logic [1:0] err_count;
	logic [ND-1:0] done_set;
	logic [ND-1:0] done_clr;
	logic sw_desc_wr;
	logic async_evt;

	always_comb begin
		st_next = st_reg;
		reload = st_reg.desc[hnr_pkg::F_RELOAD_LSB +: 4];
		nak_countdown = st_reg.desc[hnr_pkg::F_NAK_LSB +: 4];
		err_count = st_reg.desc[hnr_pkg::F_ERR_LSB +: 2];
		done_set = '0;
		done_clr = '0;
		async_evt = 1'b0;
		sw_desc_wr = reg_wr && desc_hit;
		mem_wr_en = sw_desc_wr;
		mem_wr_addr = desc_idx;
		mem_wr_data = reg_wdata[hnr_pkg::DESC_W-1:0];
		tok_valid = 1'b0;

		case (st_reg.state)
			hnr_pkg::ST_IDLE: begin
				st_next.state = hnr_pkg::ST_FETCH;
			end
			hnr_pkg::ST_FETCH: begin
				st_next.desc = eng_rd_data;
				if (eng_rd_data[hnr_pkg::F_VALID]) begin
					st_next.state = hnr_pkg::ST_ISSUE;
				end else begin
					st_next.ptr = st_reg.ptr + 1'b1;
					st_next.state = hnr_pkg::ST_IDLE;
				end
			end
			hnr_pkg::ST_ISSUE: begin
				tok_valid = 1'b1;
				st_next.state = hnr_pkg::ST_WAIT;
			end
			hnr_pkg::ST_WAIT: begin
				if (resp_valid) begin
					st_next.state = hnr_pkg::ST_WBACK;
					case (hnr_pkg::hnr_resp_t'(resp_code))
						hnr_pkg::RESP_NAK: begin
							if (reload == hnr_pkg::NIBBLE_ZERO) begin
								// Countdown is not consulted; straight reissue
								st_next.state = hnr_pkg::ST_ISSUE; // R1 R3
							end else if (nak_countdown <= hnr_pkg::NIBBLE_ONE) begin
								st_next.desc[hnr_pkg::F_NAK_LSB +: 4] = hnr_pkg::NIBBLE_ZERO;
								st_next.desc[hnr_pkg::F_VALID] = 1'b0; // R2
							end else begin
								st_next.desc[hnr_pkg::F_NAK_LSB +: 4] =
									nak_countdown - hnr_pkg::NIBBLE_ONE; // R2
							end
						end
						hnr_pkg::RESP_ERR: begin
							if (err_count <= hnr_pkg::ERR_ONE) begin
								st_next.desc[hnr_pkg::F_ERR_LSB +: 2] = hnr_pkg::ERR_ZERO;
								st_next.desc[hnr_pkg::F_HALT] = 1'b1;
								st_next.desc[hnr_pkg::F_VALID] = 1'b0;
							end else begin
								st_next.desc[hnr_pkg::F_ERR_LSB +: 2] =
									err_count - hnr_pkg::ERR_ONE;
							end
						end
						default: begin
							st_next.desc[hnr_pkg::F_VALID] = 1'b0; // R3
						end
					endcase
				end
			end
			hnr_pkg::ST_WBACK: begin
				// Software store has the port this cycle; engine waits one more
				if (!sw_desc_wr) begin
					mem_wr_en = 1'b1;
					mem_wr_addr = st_reg.ptr;
					mem_wr_data = st_reg.desc; // R7
					if (!st_reg.desc[hnr_pkg::F_VALID]) begin
						done_set[st_reg.ptr] = 1'b1;
						async_evt = 1'b1;
					end
					st_next.ptr = st_reg.ptr + 1'b1;
					st_next.state = hnr_pkg::ST_IDLE;
				end
			end
			default: begin
				st_next.state = hnr_pkg::ST_IDLE;
			end
		endcase

		// Frame tick
		if (st_reg.frame_cnt == FRAME_LAST) begin
			st_next.frame_cnt = '0;
		end else begin
			st_next.frame_cnt = st_reg.frame_cnt + 1'b1;
		end

		// Register reads; bitmap read returns and clears the same snapshot
		st_next.rdata = '0;
		st_next.desc_rd = 1'b0;
		if (reg_rd) begin
			if (reg_addr == hnr_pkg::OFS_HOST_INTERRUPT_FLAGS) begin
				st_next.rdata[hnr_pkg::FLAG_SOF] = st_reg.sof_flag;
				st_next.rdata[hnr_pkg::FLAG_ASYNC_LIST_IRQ] =
					st_reg.async_flag | (|st_reg.done_map); // R6
			end else if (reg_addr == hnr_pkg::OFS_IRQ_ENABLE) begin
				st_next.rdata = st_reg.enable;
			end else if (reg_addr == hnr_pkg::OFS_DONE_BITMAP) begin
				st_next.rdata[ND-1:0] = st_reg.done_map;
				done_clr = st_reg.done_map; // R5
			end else if (desc_hit) begin
				st_next.desc_rd = 1'b1; // Store port registers the word this same edge
			end
		end

		// Flags: write one to clear, a set in the same cycle wins
		st_next.async_flag = st_reg.async_flag;
		st_next.sof_flag = st_reg.sof_flag;
		if (reg_wr && reg_addr == hnr_pkg::OFS_HOST_INTERRUPT_FLAGS) begin
			if (reg_wdata[hnr_pkg::FLAG_ASYNC_LIST_IRQ]) begin
				st_next.async_flag = 1'b0;
			end
			if (reg_wdata[hnr_pkg::FLAG_SOF]) begin
				st_next.sof_flag = 1'b0;
			end
		end
		if (reg_wr && reg_addr == hnr_pkg::OFS_IRQ_ENABLE) begin
			st_next.enable = reg_wdata;
		end
		if (async_evt) begin
			st_next.async_flag = 1'b1; // R4
		end
		if (st_reg.frame_cnt == FRAME_LAST) begin
			st_next.sof_flag = 1'b1; // R8
		end

		// New completions survive a concurrent read
		st_next.done_map = (st_reg.done_map & ~done_clr) | done_set; // R6

		st_next.irq = (st_next.enable[hnr_pkg::FLAG_ASYNC_LIST_IRQ] &
			(st_next.async_flag | (|st_next.done_map))) |
			(st_next.enable[hnr_pkg::FLAG_SOF] & st_next.sof_flag); // R6 R8
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '{state: hnr_pkg::ST_IDLE, enable: hnr_pkg::ENABLE_RESET, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.desc_rd ? 32'(sw_rd_data) : st_reg.rdata;
	assign tok_index = st_reg.ptr;
	assign irq = st_reg.irq;
endmodule : hnr_async_engine

// ### pkg/hnr_pkg.sv
// Constants and types shared by the async-list descriptor engine
package hnr_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] OFS_HOST_INTERRUPT_FLAGS = 16'h0310;
	localparam logic [15:0] OFS_IRQ_ENABLE = 16'h0314;
	localparam logic [15:0] OFS_DONE_BITMAP = 16'h0150;
	localparam logic [15:0] OFS_DESC_BASE = 16'h0400;
	localparam logic [15:0] OFS_DESC_MASK = 16'hFFE3;
	localparam int DESC_IDX_LSB = 2;

	// Flag bits in host_interrupt_flags and irq enable
	localparam int FLAG_SOF = 1;
	localparam int FLAG_ASYNC_LIST_IRQ = 7;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Descriptor layout
	// ----------------------------------------------------------------
	localparam int NUM_DESC = 8;
	localparam int IDX_W = 3;
	localparam int DESC_W = 16;
	localparam int F_VALID = 0;
	localparam int F_RELOAD_LSB = 1;
	localparam int F_NAK_LSB = 5;
	localparam int F_ERR_LSB = 9;
	localparam int F_HALT = 11;
	localparam logic [3:0] NIBBLE_ZERO = 4'h0;
	localparam logic [3:0] NIBBLE_ONE = 4'h1;
	localparam logic [1:0] ERR_ZERO = 2'h0;
	localparam logic [1:0] ERR_ONE = 2'h1;

	// ----------------------------------------------------------------
	// Bus answers and timing
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RESP_NAK = 2'h0,
		RESP_DATA = 2'h1,
		RESP_ACK = 2'h2,
		RESP_ERR = 2'h3
	} hnr_resp_t;

	localparam int CLK_HZ = 10_000_000;
	localparam int FRAME_US = 1000;
	localparam int FRAME_CYCLES = CLK_HZ / 1_000_000 * FRAME_US;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_FETCH = 5'b00010,
		ST_ISSUE = 5'b00100,
		ST_WAIT = 5'b01000,
		ST_WBACK = 5'b10000
	} hnr_state_t;
endpackage : hnr_pkg

// ### src/hnr_desc_mem.sv
// Descriptor store with one write port and two registered read ports
`timescale 1ns/1ps
module hnr_desc_mem (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [hnr_pkg::IDX_W-1:0] wr_addr,
	input wire logic [hnr_pkg::DESC_W-1:0] wr_data,
	input wire logic [hnr_pkg::IDX_W-1:0] rd_a_addr,
	output logic [hnr_pkg::DESC_W-1:0] rd_a_data,
	input wire logic [hnr_pkg::IDX_W-1:0] rd_b_addr,
	output logic [hnr_pkg::DESC_W-1:0] rd_b_data
);
	typedef struct packed {
		logic [hnr_pkg::NUM_DESC-1:0][hnr_pkg::DESC_W-1:0] mem;
		logic [hnr_pkg::DESC_W-1:0] rd_a;
		logic [hnr_pkg::DESC_W-1:0] rd_b;
	} hnr_mem_state_t;

	hnr_mem_state_t st_reg;
	hnr_mem_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (wr_en) begin
			st_next.mem[wr_addr] = wr_data;
		end
		st_next.rd_a = st_reg.mem[rd_a_addr];
		st_next.rd_b = st_reg.mem[rd_b_addr];
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_a_data = st_reg.rd_a;
	assign rd_b_data = st_reg.rd_b;
endmodule : hnr_desc_mem

// ### tb/hnr_async_engine_checker.sv
// Port-level checker for the async-list descriptor engine
`timescale 1ns/1ps
module hnr_async_engine_checker #(
	parameter int FRAME_CYCLES = hnr_pkg::FRAME_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic tok_valid,
	input wire logic [hnr_pkg::IDX_W-1:0] tok_index,
	input wire logic resp_valid,
	input wire logic [1:0] resp_code,
	input wire logic irq
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	logic wait_reg;
	logic [31:0] en_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 1'b0;
			en_reg <= hnr_pkg::ENABLE_RESET;
		end else begin
			wait_reg <= tok_valid | (wait_reg & ~resp_valid);
			if (reg_wr && reg_addr == hnr_pkg::OFS_IRQ_ENABLE) begin
				en_reg <= reg_wdata;
			end
		end
	end
	// ----
	// Properties
	// ----
	sequence s_bm_rd;
		reg_rd && reg_addr == hnr_pkg::OFS_DONE_BITMAP && !resp_valid;
	endsequence
	property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	property p_unmapped; reg_rd && reg_addr == 16'h0200 |=> reg_rdata == 32'h0000_0000; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_tok_pulse; tok_valid |=> !tok_valid; endproperty
	a_tok_pulse: assert property (p_tok_pulse) else $error("token longer than one cycle");
	property p_one_out; tok_valid |=> !tok_valid until resp_valid; endproperty
	a_one_out: assert property (p_one_out) else $error("second token outstanding");
	property p_bm_clear;
		s_bm_rd ##1 s_bm_rd |=> (reg_rdata & $past(reg_rdata)) == 32'h0000_0000;
	endproperty
	a_bm_clear: assert property (p_bm_clear) else $error("bitmap bit returned twice");
	property p_irq_gated;
		!en_reg[hnr_pkg::FLAG_ASYNC_LIST_IRQ] && !en_reg[hnr_pkg::FLAG_SOF] |-> !irq;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("irq while disabled");
	property p_irq_ack;
		wait_reg && resp_valid && resp_code == hnr_pkg::RESP_ACK &&
			en_reg[hnr_pkg::FLAG_ASYNC_LIST_IRQ] |-> ##[1:2] irq;
	endproperty
	a_irq_ack: assert property (p_irq_ack) else $error("no irq after completion");
	property p_irq_hold; irq && !reg_wr && !reg_rd |=> irq; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped on its own");
	c_nak: cover property (resp_valid && resp_code == hnr_pkg::RESP_NAK);
	c_ack: cover property (resp_valid && resp_code == hnr_pkg::RESP_ACK);
	c_irq: cover property ($rose(irq));
endmodule : hnr_async_engine_checker

// ### tb/hnr_dev_model.sv
// Downstream device model answering each IN token after a set delay
`timescale 1ns/1ps
module hnr_dev_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tok_valid,
	input wire logic [1:0] plan_code,
	input wire logic [3:0] plan_delay,
	output logic resp_valid,
	output logic [1:0] resp_code,
	output logic [15:0] tok_count
);
	logic [3:0] wait_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			resp_valid <= 1'b0;
			resp_code <= 2'h0;
			tok_count <= 16'h0000;
			wait_reg <= 4'h0;
		end else begin
			resp_valid <= 1'b0;
			// Toggles off-strobe so a stale code is never trusted
			resp_code <= ~resp_code;
			if (tok_valid) begin
				tok_count <= tok_count + 16'h0001;
				wait_reg <= plan_delay;
			end else if (wait_reg != 4'h0) begin
				wait_reg <= wait_reg - 4'h1;
				if (wait_reg == 4'h1) begin
					resp_valid <= 1'b1;
					resp_code <= plan_code;
				end
			end
		end
	end
endmodule : hnr_dev_model

// ### tb/host_nak_retry_and_completion_test.sv
// Self-checking bench for the async-list descriptor engine
`timescale 1ns/1ps
module host_nak_retry_and_completion_test;
	localparam int FRAME = 50;
	localparam logic [15:0] A_FLG = hnr_pkg::OFS_HOST_INTERRUPT_FLAGS;
	localparam logic [15:0] A_EN = hnr_pkg::OFS_IRQ_ENABLE;
	localparam logic [15:0] A_DONE = hnr_pkg::OFS_DONE_BITMAP;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata;
	logic tok_valid;
	logic [hnr_pkg::IDX_W-1:0] tok_index;
	logic resp_valid;
	logic [1:0] resp_code;
	logic irq;
	logic [1:0] plan_code = 2'h0;
	logic [3:0] plan_delay = 4'h2;
	logic [15:0] tok_count;
	logic [31:0] rd_val;
	int num_errors = 0;
	int checks_done = 0;
	hnr_async_engine #(.FRAME_CYCLES(FRAME)) dut (.ref_clk(ref_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .tok_valid(tok_valid), .tok_index(tok_index),
		.resp_valid(resp_valid), .resp_code(resp_code), .irq(irq));
	hnr_dev_model u_dev (.ref_clk(ref_clk), .rst(rst), .tok_valid(tok_valid),
		.plan_code(plan_code), .plan_delay(plan_delay), .resp_valid(resp_valid),
		.resp_code(resp_code), .tok_count(tok_count));
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		@(negedge ref_clk);
	endtask : wr
	// Keep holds the strobe for a back-to-back read
	task automatic rd(input logic [15:0] a, input bit keep);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		rd_val = reg_rdata;
		if (!keep) begin
			reg_rd = 1'b0;
			@(negedge ref_clk);
		end
	endtask : rd
	task automatic wait_toks(input int n);
		int lim;
		lim = 0;
		while (tok_count < n && lim < 2000) begin
			@(negedge ref_clk);
			lim++;
		end
		if (lim >= 2000) begin
			num_errors++;
			$display("[FAIL] %0t token wait expired", $time);
		end
	endtask : wait_toks
	task automatic wait_irq();
		int lim;
		lim = 0;
		while (irq !== 1'b1 && lim < 2000) begin
			@(negedge ref_clk);
			lim++;
		end
		if (lim >= 2000) begin
			num_errors++;
			$display("[FAIL] %0t irq wait expired", $time);
		end
	endtask : wait_irq
	function automatic logic [31:0] dsc(input logic [3:0] rl, input logic [3:0] nk);
		return {16'h0000, 5'h00, 2'h2, nk, rl, 1'b1};
	endfunction : dsc
	// ----
	// Scenarios
	// ----
	task automatic t_hw_retry();
		plan_code = hnr_pkg::RESP_NAK;
		wr(hnr_pkg::OFS_DESC_BASE, dsc(4'h0, 4'h0));
		wait_toks(int'(tok_count) + 20);
		rd(A_FLG, 1'b0);
		chk(rd_val & 32'h0000_0080, 32'h0000_0000, "nak flag");
		rd(A_DONE, 1'b0);
		chk(rd_val, 32'h0000_0000, "nak done");
		chk(32'(tok_index), 32'h0000_0000, "retry index");
		plan_code = hnr_pkg::RESP_ACK;
		// A token already out may take the ACK, so no new token is owed
		repeat (16) @(negedge ref_clk);
		rd(A_DONE, 1'b0);
		chk(rd_val, 32'h0000_0001, "ack done");
		rd(A_DONE, 1'b0);
		chk(rd_val, 32'h0000_0000, "reread");
		rd(hnr_pkg::OFS_DESC_BASE, 1'b0);
		chk(rd_val, 32'h0000_0400, "descriptor word");
		$display("hw_retry finished");
	endtask : t_hw_retry
	task automatic t_sw_retry();
		int n;
		n = int'(tok_count);
		// Flag left by the previous completion would raise irq at once
		wr(A_FLG, 32'h0000_0080);
		wr(A_EN, 32'h0000_0080);
		plan_code = hnr_pkg::RESP_NAK;
		wr(hnr_pkg::OFS_DESC_BASE + 16'h0004, dsc(4'hF, 4'hF));
		wait_irq();
		chk(32'(int'(tok_count) - n), 32'h0000_000F, "nak count");
		rd(A_FLG, 1'b0);
		chk(rd_val & 32'h0000_0080, 32'h0000_0080, "async flag");
		rd(A_DONE, 1'b0);
		chk(rd_val, 32'h0000_0002, "countdown done");
		rd(hnr_pkg::OFS_DESC_BASE + 16'h0004, 1'b0);
		chk(rd_val, 32'h0000_041E, "spent descriptor");
		wr(A_FLG, 32'h0000_0080);
		chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
		$display("sw_retry finished");
	endtask : t_sw_retry
	task automatic t_no_loss();
		logic [31:0] acc;
		plan_delay = 4'h3;
		plan_code = hnr_pkg::RESP_ACK;
		wr(hnr_pkg::OFS_DESC_BASE + 16'h0008, dsc(4'h0, 4'h0));
		wait_irq();
		acc = 32'h0000_0000;
		wr(hnr_pkg::OFS_DESC_BASE + 16'h000C, dsc(4'h0, 4'h0));
		for (int i = 0; i < 40; i++) begin
			rd(A_DONE, i < 39);
			acc = acc | rd_val;
		end
		chk(acc, 32'h0000_000C, "bits lost");
		chk({31'h0, irq}, 32'h0000_0001, "irq held");
		wr(A_FLG, 32'h0000_0080);
		$display("no_loss finished");
	endtask : t_no_loss
	task automatic t_sof();
		wr(A_EN, 32'h0000_0002);
		wr(A_FLG, 32'hFFFF_FFFF);
		wait_irq();
		rd(A_FLG, 1'b0);
		chk(rd_val & 32'h0000_0002, 32'h0000_0002, "frame flag");
		rd(16'h0200, 1'b0);
		chk(rd_val, 32'h0000_0000, "unmapped");
		$display("sof finished");
	endtask : t_sof
	initial begin
		repeat (5000) @(posedge ref_clk);
		num_errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		@(negedge ref_clk);
		t_hw_retry();
		t_sw_retry();
		t_no_loss();
		t_sof();
		close_out();
	end
endmodule : host_nak_retry_and_completion_test
bind hnr_async_engine hnr_async_engine_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
	.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .tok_valid(tok_valid),
	.tok_index(tok_index), .resp_valid(resp_valid), .resp_code(resp_code), .irq(irq));
